// *** hw/oss_otp_access.sv ***
/*
 * Command logic for the one-time-programmable security registers of a serial flash:
 * serial framing on the link clock, programming, locking and status reads.
 * Assumes a host in SPI mode 0 or 3, a free-running system clock and a link clock
 * that only runs while the chip select is low.
 */
`timescale 1ns/1ns

module oss_otp_access
   import oss_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic       sck,
   input  wire logic       csN,
   input  wire logic       mosi,
   output logic            misoOut,
   output logic            misoOe,
   output logic            readyBusyFlag,
   output logic            writeEnableLatch,
   output logic      [2:0] otpLockFlags
);
   import oss_pkg::*;

   // Link domain
   logic       inFrameReg;
   logic [2:0] bitCntReg,   bitCntNext;
   logic [7:0] byteCntReg,  byteCntNext;
   logic [7:0] shiftReg,    shiftNext;
   logic [7:0] cmdReg,      cmdNext;
   logic [8:0] addrReg,     addrNext;
   logic [8:0] dataOffReg,  dataOffNext;
   logic       frameTogReg, frameTogNext;
   logic [7:0] bufReg [BUF_BYTES];
   logic [7:0] bufNext [BUF_BYTES];
   logic [2:0] bitBase;
   logic [7:0] byteBase;
   logic [7:0] cmdBase;
   logic [8:0] offBase;
   logic       soReg,   soNext;
   logic       soOeReg, soOeNext;
   logic [7:0] outByte;
   logic [4:0] statusLink;
   logic [7:0] arrRdData;

   // System domain
   oss_prog_state_t stateReg, stateNext;
   logic       welReg,     welNext;
   logic       csPrevReg,  csPrevNext;
   logic       linkClrReg;
   logic       togSeenReg, togSeenNext;
   logic [7:0] progIdxReg, progIdxNext;
   logic [7:0] progCntReg, progCntNext;
   logic [7:0] waitReg,    waitNext;
   logic [1:0] progSelReg, progSelNext;
   logic [6:0] progOfsReg, progOfsNext;
   logic [1:0] sysSync;
   logic       csRise;
   logic       newFrame;
   logic       wrEn;
   logic [8:0] wrAddr;
   logic [7:0] wrData;
   logic [7:0] dataBytes;
   logic [2:0] lockFlags;

   function automatic logic reg_locked(input logic [1:0] sel, input logic [2:0] flags);
      logic lk;
      lk = 1'b1;
      if (sel != 2'h0) begin
         lk = flags[sel - 2'h1];
      end
      return lk;
   endfunction : reg_locked

   // Cleared while deselected, so the first edge of a frame restarts the counters
   always_ff @(posedge sck or posedge csN) begin
      if (csN) begin
         inFrameReg <= 1'b0;
      end else begin
         inFrameReg <= 1'b1;
      end
   end

   always_comb begin
      bitBase      = inFrameReg ? bitCntReg  : 3'h0;
      byteBase     = inFrameReg ? byteCntReg : 8'h00;
      cmdBase      = inFrameReg ? cmdReg     : 8'h00;
      offBase      = inFrameReg ? dataOffReg : 9'h000;
      frameTogNext = inFrameReg ? frameTogReg : ~frameTogReg;
      shiftNext    = {shiftReg[6:0], mosi};
      bitCntNext   = bitBase + 3'h1;
      byteCntNext  = byteBase;
      if (bitBase == 3'h7 && byteBase != BYTE_CNT_MAX) begin
         byteCntNext = byteBase + 8'h01;
      end
      cmdNext = cmdBase;
      if (byteBase == 8'h00 && bitBase == 3'h7) begin
         cmdNext = shiftNext;
      end
      addrNext = addrReg;
      if (byteBase >= 8'h01 && byteBase < HDR_BYTES_ADDR) begin
         // Upper address bits fall off the top of the nine-bit register
         addrNext = {addrReg[7:0], mosi};
      end
      dataOffNext = offBase;
      bufNext     = bufReg;
      if (oss_in_data(cmdBase, byteBase) && bitBase == 3'h7) begin
         dataOffNext = offBase + 9'h001;
         if (cmdBase == CMD_PROG) begin
            // Bytes past the buffer size wrap and overwrite earlier ones
            bufNext[offBase[6:0]] = shiftNext;
         end
      end
   end

   always_ff @(posedge sck) begin
      bitCntReg   <= bitCntNext;
      byteCntReg  <= byteCntNext;
      shiftReg    <= shiftNext;
      cmdReg      <= cmdNext;
      addrReg     <= addrNext;
      dataOffReg  <= dataOffNext;
      bufReg      <= bufNext;
   end

   // The frame toggle outlives each frame, so it takes its start value from system reset
   always_ff @(posedge sck or posedge linkClrReg) begin
      if (linkClrReg) begin
         frameTogReg <= 1'b0;
      end else begin
         frameTogReg <= frameTogNext;
      end
   end

   // High through reset; it falls while the link clock stands still, so the
   // release cannot meet a link edge
   always_ff @(posedge clk) begin
      linkClrReg <= ~rstn;
   end

   // Status values reach the link domain as synchronised levels
   oss_sync #(.W(5)) uLinkSync (
      .clk  (sck),
      .din  ({lockFlags, welReg, stateReg == PS_PROG}),
      .dout (statusLink)
   );

   always_comb begin
      outByte = 8'h00;
      case (cmdReg)
         CMD_RDSR1: begin
            outByte[SR1_BUSY_BIT] = statusLink[0];
            outByte[SR1_WEL_BIT]  = statusLink[1];
         end
         CMD_RDSR2: outByte[SR2_LOCK_LSB +: 3] = statusLink[4:2];
         CMD_RDSR3: outByte = 8'h00;
         CMD_READ:  outByte = arrRdData;
         default:   outByte = 8'h00;
      endcase
      soNext   = outByte[~bitCntReg];
      soOeNext = inFrameReg && oss_in_data(cmdReg, byteCntReg) && (cmdReg != CMD_PROG);
   end

   always_ff @(negedge sck or posedge csN) begin
      if (csN) begin
         soReg   <= 1'b0;
         soOeReg <= 1'b0;
      end else begin
         soReg   <= soNext;
         soOeReg <= soOeNext;
      end
   end

   assign misoOut = soReg;
   assign misoOe  = soOeReg & ~csN;

   // System side: frame end is seen through the synchronised select
   oss_sync #(.W(2)) uSysSync (
      .clk  (clk),
      .din  ({frameTogReg, csN}),
      .dout (sysSync)
   );

   assign csRise    = sysSync[0] & ~csPrevReg;
   assign newFrame  = sysSync[1] != togSeenReg;
   assign dataBytes = byteCntReg - HDR_BYTES_ADDR;

   always_comb begin
      stateNext   = stateReg;
      welNext     = welReg;
      csPrevNext  = sysSync[0];
      togSeenNext = togSeenReg;
      progIdxNext = progIdxReg;
      progCntNext = progCntReg;
      waitNext    = waitReg;
      progSelNext = progSelReg;
      progOfsNext = progOfsReg;
      wrEn        = 1'b0;
      wrAddr      = {progSelReg, progOfsReg + progIdxReg[6:0]};
      wrData      = bufReg[progIdxReg[6:0]];
      // A frame ending while busy is marked seen too, or it would be acted on later
      if (csRise) begin
         togSeenNext = sysSync[1];
      end
      case (stateReg)
         PS_IDLE: begin
            // Link registers are stable here: the link clock is stopped
            if (csRise && newFrame) begin
               if (cmdReg == CMD_WREN && byteCntReg == 8'h01 && bitCntReg == 3'h0) begin
                  welNext = 1'b1;
               end else if (cmdReg == CMD_PROG && welReg) begin
                  welNext = 1'b0;
                  if (bitCntReg == 3'h0 && byteCntReg > HDR_BYTES_ADDR &&
                      !reg_locked(addrReg[8:7], lockFlags)) begin
                     stateNext   = PS_PROG;
                     progSelNext = addrReg[8:7];
                     progOfsNext = addrReg[6:0];
                     progIdxNext = 8'h00;
                     progCntNext = (dataBytes > BUF_BYTES) ? BUF_BYTES : dataBytes;
                     waitNext    = BYTE_PROG_CYCLES - 8'h01;
                  end
               end
            end
         end
         PS_PROG: begin
            if (waitReg != 8'h00) begin
               waitNext = waitReg - 8'h01;
            end else begin
               wrEn        = 1'b1;
               progIdxNext = progIdxReg + 8'h01;
               waitNext    = BYTE_PROG_CYCLES - 8'h01;
               if (progIdxReg + 8'h01 == progCntReg) begin
                  stateNext = PS_IDLE;
               end
            end
         end
         default: stateNext = PS_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         stateReg   <= PS_IDLE;
         welReg     <= 1'b0;
         csPrevReg  <= 1'b1;
         togSeenReg <= 1'b0;
         progIdxReg <= 8'h00;
         progCntReg <= 8'h00;
         waitReg    <= 8'h00;
         progSelReg <= 2'h0;
         progOfsReg <= 7'h00;
      end else begin
         stateReg   <= stateNext;
         welReg     <= welNext;
         csPrevReg  <= csPrevNext;
         togSeenReg <= togSeenNext;
         progIdxReg <= progIdxNext;
         progCntReg <= progCntNext;
         waitReg    <= waitNext;
         progSelReg <= progSelNext;
         progOfsReg <= progOfsNext;
      end
   end

   // Read address wraps through all four registers
   oss_otp_array uArray (
      .clk       (clk),
      .rstn      (rstn),
      .wrEn      (wrEn),
      .wrAddr    (wrAddr),
      .wrData    (wrData),
      .rdAddr    (addrReg + dataOffReg),
      .rdData    (arrRdData),
      .lockFlags (lockFlags)
   );

   assign readyBusyFlag    = (stateReg == PS_PROG);
   assign writeEnableLatch = welReg;
   assign otpLockFlags     = lockFlags;
endmodule : oss_otp_access

// *** hw/oss_pkg.sv ***
/*
 * Shared constants, types and decode helpers for the OTP security register access logic.
 * Assumes a 100 MHz system clock and a serial link in SPI mode 0 or 3.
 */
package oss_pkg;

   // Opcodes
   localparam logic [7:0] CMD_WREN  = 8'h06;
   localparam logic [7:0] CMD_PROG  = 8'h9B;
   localparam logic [7:0] CMD_READ  = 8'h4B;
   localparam logic [7:0] CMD_RDSR1 = 8'h05;
   localparam logic [7:0] CMD_RDSR2 = 8'h35;
   localparam logic [7:0] CMD_RDSR3 = 8'h15;

   // Frame layout: byte counts before the data phase
   localparam logic [7:0] HDR_BYTES_STAT = 8'h01;
   localparam logic [7:0] HDR_BYTES_ADDR = 8'h04;
   localparam logic [7:0] HDR_BYTES_READ = 8'h05;
   localparam logic [7:0] BYTE_CNT_MAX   = 8'hFF;

   // Array geometry
   localparam int          REG_COUNT     = 4;
   localparam int          REG_BYTES     = 128;
   localparam int          ARRAY_BYTES   = 512;
   localparam logic [7:0]  BUF_BYTES     = 8'h80;
   localparam logic [6:0]  LOCK_BYTE_OFS = 7'h7F;
   localparam logic [7:0]  ERASED_BYTE   = 8'hFF;

   // Status bit positions
   localparam int SR1_BUSY_BIT = 0;
   localparam int SR1_WEL_BIT  = 1;
   localparam int SR2_LOCK_LSB = 3;

   // Timing
   localparam int          CLK_PERIOD_NS    = 10;
   localparam int          BYTE_PROG_NS     = 1000;
   localparam int          BYTE_PROG_CYC    = (BYTE_PROG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0]  BYTE_PROG_CYCLES = 8'(BYTE_PROG_CYC);

   typedef enum {PS_IDLE, PS_PROG} oss_prog_state_t;

   // Arbitrary factory pattern for register zero
   function automatic logic [7:0] oss_factory_byte(input logic [6:0] idx);
      return {1'b0, idx} ^ 8'hA5;
   endfunction : oss_factory_byte

   // True once the header of a program, read or status command has been shifted in
   function automatic logic oss_in_data(input logic [7:0] cmd, input logic [7:0] byteCnt);
      logic hit;
      hit = 1'b0;
      case (cmd)
         CMD_PROG:  hit = (byteCnt >= HDR_BYTES_ADDR);
         CMD_READ:  hit = (byteCnt >= HDR_BYTES_READ);
         CMD_RDSR1: hit = (byteCnt >= HDR_BYTES_STAT);
         CMD_RDSR2: hit = (byteCnt >= HDR_BYTES_STAT);
         CMD_RDSR3: hit = (byteCnt >= HDR_BYTES_STAT);
         default:   hit = 1'b0;
      endcase
      return hit;
   endfunction : oss_in_data

endpackage : oss_pkg

// *** hw/oss_sync.sv ***
/*
 * Two flip-flop level synchroniser, one per bit.
 * Assumes the inputs are levels that hold long enough to be seen.
 */
`timescale 1ns/1ns
module oss_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] stage1Reg;
   logic [W-1:0] stage2Reg;

   // No reset: the stages only carry a level that settles within two edges
   always_ff @(posedge clk) begin
      stage1Reg <= din;
      stage2Reg <= stage1Reg;
   end

   assign dout = stage2Reg;
endmodule : oss_sync

// *** hw/oss_otp_array.sv ***
/*
 * Four 128-byte one-time-programmable registers held in flip-flops, with lock flags.
 * Assumes writes come from the system clock domain and that reads from the link
 * domain are not made while a write is under way.
 */
`timescale 1ns/1ns
module oss_otp_array
   import oss_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic       wrEn,
   input  wire logic [8:0] wrAddr,
   input  wire logic [7:0] wrData,
   input  wire logic [8:0] rdAddr,
   output logic      [7:0] rdData,
   output logic      [2:0] lockFlags
);
   logic [7:0] memReg  [ARRAY_BYTES];
   logic [7:0] memNext [ARRAY_BYTES];

   // Programming can only clear bits, as a real fuse would
   always_comb begin
      memNext = memReg;
      if (wrEn) begin
         memNext[wrAddr] = memReg[wrAddr] & wrData;
      end
   end

   // Reset stands in for power-up contents; the array itself is not volatile
   always_ff @(posedge clk) begin
      if (!rstn) begin
         for (int i = 0; i < ARRAY_BYTES; i++) begin
            memReg[i] <= (i < REG_BYTES) ? oss_factory_byte(7'(i)) : ERASED_BYTE;
         end
      end else begin
         memReg <= memNext;
      end
   end

   assign rdData = memReg[rdAddr];

   genvar g;
   generate
      for (g = 0; g < REG_COUNT - 1; g++) begin : gLock
         // Any programmed bit in the top byte locks the register
         assign lockFlags[g] = (memReg[(g + 1) * REG_BYTES + int'(LOCK_BYTE_OFS)]
                                != ERASED_BYTE);
      end
   endgenerate
endmodule : oss_otp_array

// *** dv/oss_spi_host.sv ***
/* SPI host model: mode 0 frames on a 48 ns link clock, bytes MSB first.
   Assumes one caller, which waits for each frame to end. */
`timescale 1ns/1ns
module oss_spi_host (
   output logic      sck,
   output logic      csN,
   output logic      mosi,
   input  wire logic misoOut,
   input  wire logic misoOe
);
   logic [7:0] rxByte;
   event       rxDone;
   // Select rises just after time zero so the link flops see a clean clearing edge
   initial begin
      sck = 1'b0;
      mosi = 1'b0;
      #1 csN = 1'b1;
   end
   // Clock stands still outside frames; reply bits sampled while the output is not enabled count as unknown
   task automatic frame(input logic [7:0] tx[$], input int nb, input int nrx);
      logic [7:0] r;
      csN = 1'b0;
      for (int i = 0; i < nb + 8 * nrx; i++) begin
         mosi = (i < nb) ? tx[i / 8][7 - i % 8] : 1'b0;
         #24 sck = 1'b1;
         if (i >= nb) begin
            r = {r[6:0], (misoOe === 1'b1) ? misoOut : 1'bx};
            if ((i - nb) % 8 == 7) begin
               rxByte = r;
               ->rxDone;
            end
         end
         #24 sck = 1'b0;
      end
      #24 csN = 1'b1;
      mosi = ~mosi;
      #200;
   endtask : frame
endmodule : oss_spi_host

// *** dv/oss_otp_access_checker.sv ***
/* Port-level assertions for the OTP access block, bound to its top.
   Assumes the link clock stands still while the chip select is high. */
`timescale 1ns/1ns
module oss_otp_access_checker
   import oss_pkg::*;
(
   input wire logic       clk,
   input wire logic       rstn,
   input wire logic       sck,
   input wire logic       csN,
   input wire logic       mosi,
   input wire logic       misoOut,
   input wire logic       misoOe,
   input wire logic       readyBusyFlag,
   input wire logic       writeEnableLatch,
   input wire logic [2:0] otpLockFlags
);
   logic [5:0]  edgeReg, edgeNext;
   logic [7:0]  opReg, opNext;
   logic [13:0] busyCntReg, busyCntNext;
   always_comb begin
      edgeNext = (edgeReg == 6'h3F) ? edgeReg : edgeReg + 6'h01;
      opNext = (edgeReg < 6'h08) ? {opReg[6:0], mosi} : opReg;
      busyCntNext = readyBusyFlag ? busyCntReg + 14'h0001 : 14'h0000;
   end
   // Link side has no reset of its own, so the chip select clears it
   always_ff @(posedge sck or posedge csN) begin
      if (csN) begin
         edgeReg <= 6'h00;
         opReg <= 8'h00;
      end else begin
         edgeReg <= edgeNext;
         opReg <= opNext;
      end
   end
   always_ff @(posedge clk) begin
      if (!rstn) begin
         busyCntReg <= 14'h0000;
      end else begin
         busyCntReg <= busyCntNext;
      end
   end
   a_oe_idle: assert property (@(posedge clk) disable iff (!rstn)
      csN |-> !misoOe) else $error("output enabled while deselected");
   // Sampled one falling edge late, hence edges 9 and 41
   a_data_start: assert property (@(negedge sck) disable iff (csN)
      $rose(misoOe) |-> (edgeReg == 6'h29 && opReg == CMD_READ) || (edgeReg == 6'h09 &&
      (opReg == CMD_RDSR1 || opReg == CMD_RDSR2 || opReg == CMD_RDSR3)))
      else $error("read data began at the wrong edge");
   a_busy_after_frame: assert property (@(posedge clk) disable iff (!rstn)
      $rose(readyBusyFlag) |-> csN && $past(csN, 2)) else $error("busy without frame end");
   a_wel_cleared: assert property (@(posedge clk) disable iff (!rstn)
      $fell(readyBusyFlag) |-> !writeEnableLatch) else $error("write enable kept");
   a_wel_set_idle: assert property (@(posedge clk) disable iff (!rstn)
      $rose(writeEnableLatch) |-> csN && !readyBusyFlag) else $error("bad enable set");
   a_lock_sticky: assert property (@(posedge clk) disable iff (!rstn)
      ($past(otpLockFlags) & ~otpLockFlags) == 3'h0) else $error("lock flag cleared");
   a_lock_when_busy: assert property (@(posedge clk) disable iff (!rstn)
      $changed(otpLockFlags) |-> readyBusyFlag || $past(readyBusyFlag))
      else $error("lock changed while idle");
   a_busy_bounded: assert property (@(posedge clk) disable iff (!rstn)
      busyCntReg <= 14'h3203) else $error("busy too long");
   a_oe_when_reading: assert property (@(posedge sck) disable iff (csN)
      misoOe |-> (opReg == CMD_READ && edgeReg >= 6'h28) || (edgeReg >= 6'h08 &&
      (opReg == CMD_RDSR1 || opReg == CMD_RDSR2 || opReg == CMD_RDSR3)))
      else $error("output enabled outside a read phase");
endmodule : oss_otp_access_checker

bind oss_otp_access oss_otp_access_checker u_chk (.clk(clk), .rstn(rstn), .sck(sck),
   .csN(csN), .mosi(mosi), .misoOut(misoOut), .misoOe(misoOe),
   .readyBusyFlag(readyBusyFlag), .writeEnableLatch(writeEnableLatch),
   .otpLockFlags(otpLockFlags));

// *** dv/tb_oss_otp_access.sv ***
/* Self-checking bench for the OTP access block driven by the SPI host model.
   Assumes the package, design, host model and checker are compiled first. */
`timescale 1ns/1ns
module tb_oss_otp_access;
   import oss_pkg::*;
   logic       clk = 1'b0;
   logic       rstn = 1'b0;
   logic       sck, csN, mosi, misoOut, misoOe, readyBusyFlag, writeEnableLatch;
   logic [2:0] otpLockFlags, lockExp;
   logic [7:0] mem [512];
   logic [7:0] expQ [$];
   int         n_mismatch = 0;
   int         checked = 0;
   int         cyc = 0;
   int         busyLen = 0;

   always #5 clk = ~clk;
   oss_spi_host host (.sck(sck), .csN(csN), .mosi(mosi), .misoOut(misoOut), .misoOe(misoOe));
   oss_otp_access dut (.clk(clk), .rstn(rstn), .sck(sck), .csN(csN), .mosi(mosi),
      .misoOut(misoOut), .misoOe(misoOe), .readyBusyFlag(readyBusyFlag),
      .writeEnableLatch(writeEnableLatch), .otpLockFlags(otpLockFlags));

   task automatic end_sim;
      if (n_mismatch == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_sim

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : chk

   always @(posedge clk) begin
      cyc++;
      if (readyBusyFlag === 1'b1) begin
         busyLen++;
      end
      if (cyc == 60000) begin
         n_mismatch++;
         end_sim();
      end
   end

   initial forever begin
      @(host.rxDone);
      chk(host.rxByte, expQ.pop_front());
   end

   task automatic st(input logic [7:0] op, input logic [7:0] e, input int n);
      repeat (n) expQ.push_back(e);
      host.frame({op}, 8, n);
   endtask : st

   task automatic rd(input logic [8:0] a, input int n);
      logic [23:0] ad;
      ad = {15'($urandom), a};
      for (int i = 0; i < n; i++) expQ.push_back(mem[9'(a + i)]);
      host.frame({CMD_READ, ad[23:16], ad[15:8], ad[7:0], 8'h00}, 40, n);
   endtask : rd

   // Cut drops trailing bits so the frame ends off a byte boundary
   task automatic prog(input logic [8:0] a, input logic [7:0] d[$], input int cut,
                       input logic write_enable_latch, input logic ok);
      logic [23:0] ad;
      logic [8:0]  w;
      logic [7:0]  tx[$];
      ad = {15'($urandom), a};
      tx = {CMD_PROG, ad[23:16], ad[15:8], ad[7:0]};
      foreach (d[i]) tx.push_back(d[i]);
      if (write_enable_latch) host.frame({CMD_WREN}, 8, 0);
      chk(writeEnableLatch, write_enable_latch);
      busyLen = 0;
      host.frame(tx, 32 + 8 * d.size() - cut, 0);
      if (ok) begin
         st(CMD_RDSR1, 8'h01, 1);
         for (int k = 0; k < 14000 && readyBusyFlag !== 1'b0; k++) @(negedge clk);
         chk(16'(busyLen >= 100 * d.size() && busyLen <= 100 * d.size() + 4), 16'h1);
         foreach (d[i]) begin
            w = {a[8:7], 7'(a[6:0] + i)};
            mem[w] = d[i];
            if (w[6:0] == LOCK_BYTE_OFS) lockExp[w[8:7] - 2'h1] = 1'b1;
         end
      end
      repeat (10) @(negedge clk);
      chk(readyBusyFlag, 1'b0);
      st(CMD_RDSR1, 8'h00, 1);
      st(CMD_RDSR2, {2'b00, lockExp, 3'b000}, 1);
      chk(otpLockFlags, lockExp);
   endtask : prog

   initial begin
      void'($urandom(32'hA64D));
      lockExp = 3'b000;
      // Register zero holds the arbitrary factory pattern, the rest is erased
      for (int i = 0; i < 512; i++) mem[i] = (i < 128) ? (8'(i) ^ 8'hA5) : 8'hFF;
      repeat (16) @(negedge clk);
      rstn = 1'b1;
      repeat (3) @(negedge clk);
      st(CMD_RDSR1, 8'h00, 2);
      st(CMD_RDSR2, 8'h00, 1);
      st(CMD_RDSR3, 8'h00, 1);
      rd(9'h07E, 4);
      prog(9'h085, {8'($urandom), 8'($urandom), 8'($urandom)}, 0, 1, 1);
      prog(9'h0A0, {8'h00}, 0, 0, 0);
      prog(9'h010, {8'h00, 8'h00}, 0, 1, 0);
      prog(9'h090, {8'h00, 8'h00}, 4, 1, 0);
      prog(9'h090, {8'h00}, 20, 1, 0);
      prog(9'h085, {mem[9'h085] & 8'($urandom), mem[9'h086] & 8'($urandom)}, 0, 1, 1);
      prog(9'h17F, {8'h5A, 8'($urandom)}, 0, 1, 1);
      prog(9'h120, {8'h00, 8'h00}, 0, 1, 0);
      rd(9'h000, 514);
      end_sim();
   end
endmodule : tb_oss_otp_access
